// file: bench/spsel_checker.sv
`timescale 1ns/100ps
module spsel_checker (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // observed ports
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       sck_out,
  input wire logic       sck_oe,
  input wire logic       mosi_out,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic       nss_in,
  input wire logic       nss_out,
  input wire logic       nss_oe,
  input wire logic       nss_pin_mapped
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // select held high long enough to pass the synchroniser
  sequence s_desel;
    nss_in [*4] ##0 (nss_pin_mapped && !nss_oe);
  endsequence
  sequence s_sck_high;
    $rose(sck_out) ##0 sck_out [*4];
  endsequence
  sequence s_fault_edge;
    sck_oe && nss_pin_mapped && !nss_oe && $fell(nss_in);
  endsequence

  a_master_pins: assert property (sck_oe |-> mosi_oe && !miso_oe)
    else $error("pin directions wrong while master");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_mosi_stable: assert property (sck_oe && $rose(sck_out) |-> $stable(mosi_out))
    else $error("mosi moved at sampling edge");
  a_sck_idle: assert property (!sck_oe [*2] |-> !sck_out)
    else $error("sck driven while not master");
  a_sck_half: assert property (s_sck_high |=> !sck_out)
    else $error("sck high phase not four clocks");
  a_fault_drop: assert property (s_fault_edge |-> ##[1:6] !sck_oe)
    else $error("master kept bus after select fall");
  a_desel_float: assert property (s_desel |-> !miso_oe)
    else $error("miso driven while deselected");
  a_sel_unmapped: assert property (!nss_pin_mapped |-> !nss_oe && !nss_out)
    else $error("select active in three wire mode");
  a_sel_drive: assert property (nss_oe |-> nss_pin_mapped)
    else $error("select driven but not mapped");
endmodule

bind spsel_core spsel_checker u_chk (
  .clock(clock), .rst_n(rst_n), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
  .miso_oe(miso_oe), .nss_in(nss_in), .nss_out(nss_out), .nss_oe(nss_oe),
  .nss_pin_mapped(nss_pin_mapped)
);

// file: bench/spsel_partner.sv
`timescale 1ns/100ps
module spsel_partner (
  // clock
  input  wire logic clock,
  // bus levels
  input  wire logic sck_w,
  input  wire logic mosi_w,
  input  wire logic nss_w,
  input  wire logic slave_on,
  input  wire logic miso_w,
  // far side drive
  output logic      sck,
  output logic      mosi,
  output logic      nss_n,
  output logic      miso
);
  logic [7:0] s_tx = 8'h69;
  logic [7:0] s_rx = 8'h00;
  logic       s_junk = 1'b0;

  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    nss_n = 1'b1;
  end

  task automatic drive_sel(input logic v);
    @(posedge clock);
    nss_n <= v;
  endtask

  // msb first, sck still outside frames
  task automatic xfer(input logic [7:0] tx, input int n, input logic sel, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    @(posedge clock);
    nss_n <= ~sel;
    // select leads the first edge by eight clocks
    repeat (4) @(posedge clock);
    for (i = 0; i < n; i++) begin
      mosi <= tx[7-i];
      repeat (4) @(posedge clock);
      sck <= 1'b1;
      rx = {rx[6:0], miso_w};
      repeat (4) @(posedge clock);
      sck <= 1'b0;
    end
    repeat (4) @(posedge clock);
    // released line shows the inverse of its last value
    mosi <= ~mosi;
    nss_n <= 1'b1;
  endtask

  // lone slave when the device masters
  always @(posedge sck_w) if (slave_on) s_rx <= {s_rx[6:0], mosi_w};
  always @(negedge sck_w) if (slave_on) s_tx <= {s_tx[6:0], 1'b1};
  // undriven miso toggles so no stale level passes
  always @(posedge clock) s_junk <= ~s_junk;
  assign miso = (slave_on && !nss_w) ? s_tx[7] : s_junk;
endmodule

// file: bench/tb_spsel_core.sv
`timescale 1ns/100ps
module tb_spsel_core;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic       irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic       nss_out, nss_oe, nss_pin_mapped;
  logic       p_sck, p_mosi, p_nss_n, p_miso;
  logic [7:0] got;
  int         fail_count = 0;
  int         compares = 0;
  wire        sck_w = sck_oe ? sck_out : p_sck;
  wire        mosi_w = mosi_oe ? mosi_out : p_mosi;
  wire        miso_w = miso_oe ? miso_out : p_miso;
  wire        nss_w = nss_oe ? nss_out : p_nss_n;

  initial forever #25 clock = ~clock;

  spsel_core dut (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe(miso_oe), .nss_in(nss_w), .nss_out(nss_out), .nss_oe(nss_oe),
    .nss_pin_mapped(nss_pin_mapped)
  );

  spsel_partner far (
    .clock(clock), .sck_w(sck_w), .mosi_w(mosi_w), .nss_w(nss_w), .slave_on(sck_oe), .miso_w(miso_w),
    .sck(p_sck), .mosi(p_mosi), .nss_n(p_nss_n), .miso(p_miso)
  );

  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // outputs are looked at only after the write has landed
    @(negedge clock);
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    got = reg_rdata;
  endtask

  // polling is bounded so a stuck master ends the run
  task automatic wait_done();
    int k;
    for (k = 0; k < 80; k++) begin
      rd(spsel_pkg::REG_STATUS);
      if (got[spsel_pkg::ST_DONE] === 1'b1) break;
    end
    if (k == 80) begin
      fail_count++;
      test_done();
    end
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rd(spsel_pkg::REG_CTRL);
    check(got, {4'h0, spsel_pkg::MODE_RESET, 2'b00});
    rd(spsel_pkg::REG_STATUS);
    check(got, 8'h00);
    rd(4'hf);
    check(got, 8'h00);
    check({4'h0, nss_pin_mapped, nss_oe, miso_oe, sck_oe}, 8'h08);
    // four wire slave, aborted partial byte first
    wr(spsel_pkg::REG_MASK, 8'h03);
    wr(spsel_pkg::REG_CTRL, 8'h05);
    far.xfer(8'hff, 3, 1'b1, got);
    wr(spsel_pkg::REG_DATA, 8'ha5);
    far.xfer(8'h3c, 8, 1'b1, got);
    check(got, 8'ha5);
    rd(spsel_pkg::REG_STATUS);
    check(got, 8'h01);
    check({7'h0, irq}, 8'h01);
    check({7'h0, miso_oe}, 8'h00);
    rd(spsel_pkg::REG_DATA);
    check(got, 8'h3c);
    wr(spsel_pkg::REG_STATUS, 8'h01);
    far.xfer(8'h00, 8, 1'b0, got);
    rd(spsel_pkg::REG_STATUS);
    check(got, 8'h00);
    check({7'h0, irq}, 8'h00);
    // three wire slave ignores the select level
    wr(spsel_pkg::REG_CTRL, 8'h01);
    wr(spsel_pkg::REG_DATA, 8'hc3);
    check({6'h0, nss_pin_mapped, miso_oe}, 8'h01);
    far.xfer(8'h5a, 8, 1'b0, got);
    check(got, 8'hc3);
    rd(spsel_pkg::REG_DATA);
    check(got, 8'h5a);
    wr(spsel_pkg::REG_STATUS, 8'h01);
    // master with select output
    wr(spsel_pkg::REG_CTRL, 8'h0f);
    check({6'h0, nss_oe, nss_out}, 8'h03);
    wr(spsel_pkg::REG_CTRL, 8'h0b);
    check({3'h0, nss_oe, nss_out, sck_oe, mosi_oe, miso_oe}, 8'h16);
    wr(spsel_pkg::REG_DATA, 8'h96);
    wait_done();
    check(far.s_rx, 8'h96);
    rd(spsel_pkg::REG_DATA);
    check(got, 8'h69);
    wr(spsel_pkg::REG_STATUS, 8'h01);
    // multi-master fault on select fall
    wr(spsel_pkg::REG_CTRL, 8'h07);
    far.drive_sel(1'b0);
    repeat (8) @(posedge clock);
    rd(spsel_pkg::REG_CTRL);
    check(got, 8'h04);
    rd(spsel_pkg::REG_STATUS);
    check(got, 8'h02);
    check({7'h0, irq}, 8'h01);
    far.drive_sel(1'b1);
    wr(spsel_pkg::REG_STATUS, 8'h02);
    rd(spsel_pkg::REG_STATUS);
    check({got[3:0], 3'h0, irq}, 8'h00);
    test_done();
  end
endmodule

// file: core/spsel_core.sv
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
module spsel_core (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // interrupt
  output logic            irq,
  // serial clock pin
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  // master out slave in pin
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe,
  // master in slave out pin
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe,
  // select pin
  input  wire logic       nss_in,
  output logic            nss_out,
  output logic            nss_oe,
  output logic            nss_pin_mapped
);

  spsel_sync_if pins ();

  // control state
  logic                   port_enable_bit;
  logic                   master_enable_bit;
  spsel_pkg::spsel_mode_t select_mode_field;

  // data path state
  logic [7:0]             shift_reg;
  logic [7:0]             tx_buf;
  logic                   tx_full;
  logic [7:0]             rx_buf;
  logic                   rx_full;
  logic [3:0]             bit_cnt;
  logic                   sample_bit;

  // master clock generator
  logic                   m_busy;
  logic [3:0]             half_cnt;
  logic                   sck_level;

  // flags and mask
  logic                   transfer_done_flag;
  logic                   mode_fault_flag;
  logic                   write_coll_flag;
  logic                   overrun_flag;
  logic [3:0]             irq_mask;

  // combinational terms
  logic                   is_master;
  logic                   slave_selected;
  logic                   m_tick;
  logic                   m_rise;
  logic                   m_fall;
  logic                   rise_ev;
  logic                   fall_ev;
  logic                   data_in;
  logic                   idle;
  logic                   load_sr;
  logic                   byte_done;
  logic                   fault_ev;
  logic                   nss_fall_4w;
  logic                   wr_ctrl;
  logic                   wr_data;
  logic                   wr_status;
  logic                   wr_mask;
  logic                   rd_data;
  logic [3:0]             flag_vec;

  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] idx);
    reg_hit = (addr == idx);
  endfunction

  spsel_sync u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .lanes (pins.sync)
  );

  assign pins.raw[spsel_pkg::SYNC_SCK]  = sck_in;
  assign pins.raw[spsel_pkg::SYNC_NSS]  = nss_in;
  assign pins.raw[spsel_pkg::SYNC_MOSI] = mosi_in;
  assign pins.raw[spsel_pkg::SYNC_MISO] = miso_in;

  assign wr_ctrl   = reg_write & reg_hit(reg_addr, spsel_pkg::REG_CTRL);
  assign wr_data   = reg_write & reg_hit(reg_addr, spsel_pkg::REG_DATA);
  assign wr_status = reg_write & reg_hit(reg_addr, spsel_pkg::REG_STATUS);
  assign wr_mask   = reg_write & reg_hit(reg_addr, spsel_pkg::REG_MASK);
  assign rd_data   = reg_read & reg_hit(reg_addr, spsel_pkg::REG_DATA);

  // master_enable_bit alone does nothing while the port is off
  assign is_master = port_enable_bit & master_enable_bit;

  // 4-wire slave selected while select input is low
  // mode 1x as slave is a misuse; it is treated as selected
  always_comb begin
    unique case (select_mode_field)
      spsel_pkg::SEL_FOUR_IN: slave_selected = ~pins.level[spsel_pkg::SYNC_NSS];
      default:                slave_selected = 1'b1;
    endcase
  end

  assign nss_fall_4w = port_enable_bit & (select_mode_field == spsel_pkg::SEL_FOUR_IN)
                       & pins.fall[spsel_pkg::SYNC_NSS];

  // another master pulling select low takes the bus from us
  assign fault_ev = nss_fall_4w & master_enable_bit;

  assign m_tick = m_busy & (half_cnt == spsel_pkg::SCK_HALF_CYC - 4'h1);
  assign m_rise = m_tick & ~sck_level;
  assign m_fall = m_tick & sck_level;

  // synchronised slave edges lag the pin by two to three clocks
  // deselected slave sees no edges
  assign rise_ev = is_master ? m_rise
                 : (port_enable_bit & slave_selected & pins.rise[spsel_pkg::SYNC_SCK]);
  assign fall_ev = is_master ? m_fall
                 : (port_enable_bit & slave_selected & pins.fall[spsel_pkg::SYNC_SCK]);

  // the master samples synchronised MISO; a four-clock half period covers the lag
  assign data_in   = is_master ? pins.level[spsel_pkg::SYNC_MISO] : pins.level[spsel_pkg::SYNC_MOSI];
  assign idle      = is_master ? ~m_busy : (bit_cnt == 4'h0);
  assign load_sr   = port_enable_bit & tx_full & idle & ~fault_ev;
  assign byte_done = fall_ev & (bit_cnt == spsel_pkg::BITS_PER_BYTE);

  // control register; a fault in the same cycle wins over a write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_enable_bit   <= 1'b0;
      master_enable_bit <= 1'b0;
      select_mode_field <= spsel_pkg::spsel_mode_t'(spsel_pkg::MODE_RESET);
    end else begin
      if (wr_ctrl) begin
        port_enable_bit   <= reg_wdata[spsel_pkg::CTRL_PORT_EN];
        master_enable_bit <= reg_wdata[spsel_pkg::CTRL_MASTER_EN];
        select_mode_field <= spsel_pkg::spsel_mode_t'(reg_wdata[spsel_pkg::CTRL_MODE_HI:spsel_pkg::CTRL_MODE_LO]);
      end
      // fault turns the port off until software re-enables it
      if (fault_ev) begin
        port_enable_bit   <= 1'b0;
        master_enable_bit <= 1'b0;
      end
    end
  end

  // transmit buffer; a write while it is still full is dropped
  // the collision flag below tells software that its byte was lost
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf  <= spsel_pkg::DATA_RESET;
      tx_full <= 1'b0;
    end else begin
      if (wr_data && !tx_full) begin
        tx_buf  <= reg_wdata;
        tx_full <= 1'b1;
      end else if (load_sr) begin
        tx_full <= 1'b0;
      end
    end
  end

  // master clock generator, idle low
  // a fault stops the clock at once; the partial byte is dropped
  // only the master makes SCK
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      m_busy    <= 1'b0;
      half_cnt  <= 4'h0;
      sck_level <= 1'b0;
    end else if (!is_master || fault_ev) begin
      m_busy    <= 1'b0;
      half_cnt  <= 4'h0;
      sck_level <= 1'b0;
    end else if (load_sr) begin
      m_busy   <= 1'b1;
      half_cnt <= 4'h0;
    end else if (m_busy) begin
      if (m_tick) begin
        half_cnt  <= 4'h0;
        sck_level <= ~sck_level;
        if (m_fall && bit_cnt == spsel_pkg::BITS_PER_BYTE) begin
          m_busy <= 1'b0;
        end
      end else begin
        half_cnt <= half_cnt + 4'h1;
      end
    end
  end

  // shift register and bit counter: sample on rising, shift on falling
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg  <= spsel_pkg::DATA_RESET;
      bit_cnt    <= 4'h0;
      sample_bit <= 1'b0;
    end else if (!port_enable_bit) begin
      // disabling is the only way to realign a 3-wire slave
      bit_cnt <= 4'h0;
    end else if (nss_fall_4w && !master_enable_bit) begin
      // select falling edge realigns the slave
      bit_cnt <= 4'h0;
    end else if (load_sr) begin
      shift_reg <= tx_buf;
      // a slave edge landing in the loading cycle is still counted;
      // a master starts its byte from zero whatever a slave left behind
      if (rise_ev) begin
        sample_bit <= data_in;
        bit_cnt    <= bit_cnt + 4'h1;
      end else begin
        bit_cnt    <= 4'h0;
      end
    end else if (rise_ev) begin
      sample_bit <= data_in;
      bit_cnt    <= bit_cnt + 4'h1;
    end else if (fall_ev) begin
      // top bit leaves first, new bit enters at the bottom
      shift_reg <= {shift_reg[6:0], sample_bit};
      if (bit_cnt == spsel_pkg::BITS_PER_BYTE) begin
        bit_cnt <= 4'h0;
      end
    end
  end

  // receive buffer; a slave keeps an unread byte and loses the new one, a master overwrites it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_buf  <= spsel_pkg::DATA_RESET;
      rx_full <= 1'b0;
    end else begin
      // completed byte copied into the receive buffer
      if (byte_done && !(rx_full && !is_master)) begin
        rx_buf  <= {shift_reg[6:0], sample_bit};
        rx_full <= 1'b1;
      end else if (rd_data) begin
        rx_full <= 1'b0;
      end
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      transfer_done_flag <= 1'b0;
      mode_fault_flag    <= 1'b0;
      write_coll_flag    <= 1'b0;
      overrun_flag       <= 1'b0;
    end else begin
      // done flag at the end of each byte
      transfer_done_flag <= (transfer_done_flag & ~(wr_status & reg_wdata[spsel_pkg::ST_DONE]))
                            | byte_done;
      mode_fault_flag    <= (mode_fault_flag & ~(wr_status & reg_wdata[spsel_pkg::ST_FAULT]))
                            | fault_ev;
      write_coll_flag    <= (write_coll_flag & ~(wr_status & reg_wdata[spsel_pkg::ST_COLL]))
                            | (wr_data & tx_full);
      overrun_flag       <= (overrun_flag & ~(wr_status & reg_wdata[spsel_pkg::ST_OVERRUN]))
                            | (byte_done & rx_full & ~is_master);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= spsel_pkg::MASK_RESET;
    end else if (wr_mask) begin
      irq_mask <= reg_wdata[3:0];
    end
  end

  assign flag_vec = {overrun_flag, write_coll_flag, mode_fault_flag, transfer_done_flag};
  // level output: high until software clears the flag or masks it
  assign irq      = |(flag_vec & irq_mask);

  // read data stand for one cycle after the strobe
  // zero outside the answer cycle, so an or-ed read bus stays clean
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= spsel_pkg::DATA_RESET;
    end else if (reg_read) begin
      unique case (reg_addr)
        spsel_pkg::REG_CTRL:   reg_rdata <= {4'h0, select_mode_field, master_enable_bit, port_enable_bit};
        spsel_pkg::REG_DATA:   reg_rdata <= rx_buf;
        spsel_pkg::REG_STATUS: reg_rdata <= {3'h0, ~idle | tx_full, flag_vec};
        spsel_pkg::REG_MASK:   reg_rdata <= {4'h0, irq_mask};
        default:               reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign sck_out  = sck_level;
  assign sck_oe   = is_master;

  // master drives MOSI from the top bit
  assign mosi_out = shift_reg[7];
  assign mosi_oe  = is_master;

  // MISO driven by a selected slave only
  assign miso_out = shift_reg[7];
  assign miso_oe  = port_enable_bit & ~master_enable_bit & slave_selected;

  // select as an output in mode 1x
  assign nss_out  = select_mode_field[0];
  assign nss_oe   = select_mode_field[1];

  assign nss_pin_mapped = (select_mode_field != spsel_pkg::SEL_THREE_WIRE);

endmodule

// file: core/spsel_pkg.sv
package spsel_pkg;

  // register indexes on the plain register port
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_DATA   = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_MASK   = 4'h3;

  // control register fields
  localparam int CTRL_PORT_EN   = 0;
  localparam int CTRL_MASTER_EN = 1;
  localparam int CTRL_MODE_LO   = 2;
  localparam int CTRL_MODE_HI   = 3;

  // status and mask register fields
  localparam int ST_DONE    = 0;
  localparam int ST_FAULT   = 1;
  localparam int ST_COLL    = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_BUSY    = 4;

  // reset values
  localparam logic [1:0] MODE_RESET   = 2'h1;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [3:0] FLAGS_RESET  = 4'h0;
  localparam logic [3:0] MASK_RESET   = 4'h0;

  // select-mode encodings
  typedef enum logic [1:0] {
    SEL_THREE_WIRE = 2'b00,
    SEL_FOUR_IN    = 2'b01,
    SEL_OUT_LOW    = 2'b10,
    SEL_OUT_HIGH   = 2'b11
  } spsel_mode_t;

  // synchroniser lanes
  localparam int SYNC_LANES = 4;
  localparam int SYNC_SCK   = 0;
  localparam int SYNC_NSS   = 1;
  localparam int SYNC_MOSI  = 2;
  localparam int SYNC_MISO  = 3;

  // timing
  localparam int          CLK_NS       = 50;
  localparam int          SCK_HALF_NS  = 200;
  localparam logic [3:0]  SCK_HALF_CYC = 4'((SCK_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

endpackage

// file: core/spsel_sync.sv
`timescale 1ns/100ps
module spsel_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pin lanes
  spsel_sync_if.sync lanes
);

  logic [spsel_pkg::SYNC_LANES-1:0] stage1;
  logic [spsel_pkg::SYNC_LANES-1:0] stage2;
  logic [spsel_pkg::SYNC_LANES-1:0] stage3;

  genvar g;
  generate
    for (g = 0; g < spsel_pkg::SYNC_LANES; g++) begin : g_lane
      // stage1 is read by stage2 only
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          stage1[g] <= 1'b0;
          stage2[g] <= 1'b0;
          stage3[g] <= 1'b0;
        end else begin
          stage1[g] <= lanes.raw[g];
          stage2[g] <= stage1[g];
          stage3[g] <= stage2[g];
        end
      end
      assign lanes.level[g] = stage2[g];
      assign lanes.rise[g]  = stage2[g] & ~stage3[g];
      assign lanes.fall[g]  = ~stage2[g] & stage3[g];
    end
  endgenerate

endmodule

// file: core/spsel_sync_if.sv
`timescale 1ns/100ps
interface spsel_sync_if;
  logic [spsel_pkg::SYNC_LANES-1:0] raw;
  logic [spsel_pkg::SYNC_LANES-1:0] level;
  logic [spsel_pkg::SYNC_LANES-1:0] rise;
  logic [spsel_pkg::SYNC_LANES-1:0] fall;

  modport sync (input raw, output level, output rise, output fall);
  modport core (output raw, input level, input rise, input fall);
endinterface
